// ===== tb/aaops_checker.sv
// Port assertions for the add/AND execution block
`timescale 1ns/1ps
`default_nettype none

module aaops_checker #(
    parameter logic [6:0] STATUS_FADDR = aaops_pkg::STATUS_FADDR_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction side
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [6:0] file_raddr,
    input wire logic [7:0] file_rdata,
    // Results
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] acc_out,
    input wire logic [2:0] flags_out,
    input wire logic exec_done
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Opcode field and operation decode
    wire [5:0] opc = instr_word[13:8];
    wire add_i = instr_valid && opc[5:1] == 5'h1f;
    wire and_i = instr_valid && opc == 6'h39;
    wire add_f = instr_valid && opc == 6'h07;
    wire and_f = instr_valid && opc == 6'h05;
    wire opr = add_f || and_f;
    wire known = add_i || and_i || opr;
    wire tgt = instr_word[7];
    // Status operand shows live flags, not stale array bits
    wire [7:0] fop = (file_raddr == STATUS_FADDR) ? {file_rdata[7:3], flags_out} : file_rdata;
    wire [7:0] b = opr ? fop : instr_word[7:0];
    // Reference sums, carries and result
    wire [8:0] sum = {1'b0, acc_out} + {1'b0, b};
    wire [4:0] hs = {1'b0, acc_out[3:0]} + {1'b0, b[3:0]};
    wire [7:0] res = (add_i || add_f) ? sum[7:0] : (acc_out & b);
    wire [2:0] fl_add = {sum[7:0] == 8'h00, hs[4], sum[8]};
    // AND into status sets carries from data, so skipped below
    wire st_dst = opr && tgt && instr_word[6:0] == STATUS_FADDR;

    a_done_known: assert property (known |=> exec_done)
        else $error("known opcode gave no done pulse");
    a_unknown_idle: assert property (instr_valid && !known |=> !exec_done && !file_we)
        else $error("unknown opcode had an effect");
    a_acc_result: assert property (known && !(opr && tgt) |=> acc_out == $past(res))
        else $error("accumulator result wrong");
    a_add_flags: assert property (add_i || add_f |=> flags_out == $past(fl_add))
        else $error("add flags wrong");
    a_and_flags: assert property ((and_i || and_f) && !st_dst
        |=> flags_out == {$past(res) == 8'h00, $past(flags_out[1:0])})
        else $error("and flags wrong");
    a_file_dest: assert property (opr && tgt
        |=> file_we && file_waddr == $past(instr_word[6:0]) && $stable(acc_out))
        else $error("file target write wrong");
    a_file_data: assert property (opr && tgt |=> file_wdata ==
        (file_waddr == STATUS_FADDR ? {$past(res[7:3]), flags_out} : $past(res)))
        else $error("file write data wrong");
    a_acc_no_we: assert property (opr && !tgt |=> !file_we)
        else $error("file written for accumulator target");
    a_raddr_word: assert property (instr_valid |-> file_raddr == instr_word[6:0])
        else $error("operand address wrong");
endmodule

bind aaops_top aaops_checker #(.STATUS_FADDR(STATUS_FADDR)) aaops_checker_inst (
    .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc_out(acc_out),
    .flags_out(flags_out), .exec_done(exec_done));

`default_nettype wire

// ===== tb/aaops_file_model.sv
// File register array on the far side of the block
`timescale 1ns/1ps
`default_nettype none

module aaops_file_model (
    // Clock
    input wire logic aclk,
    // Read port
    input wire logic [6:0] raddr,
    output logic [7:0] rdata,
    // Write port
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata
);
    // Array, also preloaded by the bench
    logic [7:0] mem [128];

    // Same-cycle read, no forwarding of a pending write
    assign rdata = mem[raddr];

    // Write on the one-cycle pulse; plain always so the bench may preload
    always @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end
endmodule

`default_nettype wire

// ===== tb/add_and_alu_ops_tb.sv
// Self-checking bench for the add/AND execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module add_and_alu_ops_tb;
    // Clock, reset, instruction side
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [6:0] file_raddr, file_waddr;
    logic [7:0] file_rdata, file_wdata, acc_out;
    logic file_we, exec_done;
    logic [2:0] flags_out;
    // Register bus, prot and strobes tied
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // Bookkeeping
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    aaops_top aaops_top_inst (
        .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr_word(instr_word),
        .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .acc_out(acc_out),
        .flags_out(flags_out), .exec_done(exec_done),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    aaops_file_model aaops_file_model_inst (
        .aclk(aclk), .raddr(file_raddr), .rdata(file_rdata),
        .we(file_we), .waddr(file_waddr), .wdata(file_wdata));

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // Hang guard, far above the hundred or fewer cycles needed
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // Verdict and end of run
    task automatic end_of_test();
    begin
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // One instruction for one cycle; done pulse seen just after
    task automatic exec(input logic [13:0] w, input logic d);
    begin
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge aclk);
        #1;
        `CHK("exec_done", d, exec_done)
    end
    endtask

    // Decoder goes quiet for one edge
    task automatic idle();
    begin
        instr_valid <= 1'b0;
        @(posedge aclk);
        #1;
    end
    endtask

    // Bus write; address and data released as each is taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
    begin
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready);
            w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
            s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
    end
    endtask

    // Bus read with expected word and response
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
    end
    endtask

    // Cleared state after reset, read-only place refuses writes
    task automatic t_reset();
    begin
        rd(4'h0, 32'h0000_0000, 2'h0);
        rd(4'h4, 32'h0000_0000, 2'h0);
        wr(4'hc, 32'h0000_00ff, 2'h2);
        $display("test reset done");
    end
    endtask

    // Add immediate, back to back, carry wrap and ignored bit 8
    task automatic t_add_imm();
    begin
        wr(4'h0, 32'h0000_0010, 2'h0);
        exec(14'h3e15, 1'b1);
        `CHK("acc", 8'h25, acc_out)
        `CHK("flags", 3'h0, flags_out)
        exec(14'h3fdb, 1'b1);
        `CHK("acc", 8'h00, acc_out)
        `CHK("flags", 3'h7, flags_out)
        idle();
        rd(4'hc, 32'h0000_0200, 2'h0);
        $display("test add_imm done");
    end
    endtask

    // AND immediate keeps both carries set beforehand
    task automatic t_and_imm();
    begin
        wr(4'h0, 32'h0000_00a3, 2'h0);
        wr(4'h4, 32'h0000_0003, 2'h0);
        exec(14'h395f, 1'b1);
        `CHK("acc", 8'h03, acc_out)
        `CHK("flags", 3'h3, flags_out)
        exec(14'h3900, 1'b1);
        `CHK("flags", 3'h7, flags_out)
        idle();
        $display("test and_imm done");
    end
    endtask

    // Add file register to each target in turn
    task automatic t_add_opr();
    begin
        aaops_file_model_inst.mem[4] = 8'hc2;
        wr(4'h0, 32'h0000_0017, 2'h0);
        exec(14'h0704, 1'b1);
        `CHK("acc", 8'hd9, acc_out)
        exec(14'h0784, 1'b1);
        `CHK("acc", 8'hd9, acc_out)
        `CHK("file_we", 1'b1, file_we)
        `CHK("wdata", 8'h9b, file_wdata)
        `CHK("flags", 3'h1, flags_out)
        idle();
        `CHK("mem", 8'h9b, aaops_file_model_inst.mem[4])
        $display("test add_opr done");
    end
    endtask

    // AND file register to file, then to accumulator
    task automatic t_and_opr();
    begin
        aaops_file_model_inst.mem[5] = 8'hc2;
        // Accumulator still holds the earlier sum, so load it afresh
        wr(4'h0, 32'h0000_0017, 2'h0);
        wr(4'h4, 32'h0000_0003, 2'h0);
        exec(14'h0585, 1'b1);
        `CHK("acc", 8'h17, acc_out)
        `CHK("wdata", 8'h02, file_wdata)
        `CHK("flags", 3'h3, flags_out)
        idle();
        exec(14'h0505, 1'b1);
        `CHK("acc", 8'h02, acc_out)
        idle();
        $display("test and_opr done");
    end
    endtask

    // Result into status: new flags beat the written bits
    task automatic t_status();
    begin
        aaops_file_model_inst.mem[3] = 8'hf8;
        wr(4'h0, 32'h0000_0008, 2'h0);
        wr(4'h4, 32'h0000_0000, 2'h0);
        exec(14'h0783, 1'b1);
        `CHK("wdata", 8'h07, file_wdata)
        idle();
        `CHK("mem", 8'h07, aaops_file_model_inst.mem[3])
        $display("test status done");
    end
    endtask

    // Unknown opcode leaves the accumulator alone
    task automatic t_refuse();
    begin
        wr(4'h0, 32'h0000_0055, 2'h0);
        exec(14'h0000, 1'b0);
        `CHK("acc", 8'h55, acc_out)
        idle();
        $display("test refuse done");
    end
    endtask

    // Software-queued add runs in the first decoder-free cycle
    task automatic t_queue();
    begin
        wr(4'h8, 32'h0000_3e15, 2'h0);
        idle();
        `CHK("acc", 8'h6a, acc_out)
        `CHK("flags", 3'h0, flags_out)
        rd(4'h8, 32'h0000_3e15, 2'h0);
        rd(4'hc, 32'h0000_026a, 2'h0);
        $display("test queue done");
    end
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_add_imm();
        t_and_imm();
        t_add_opr();
        t_and_opr();
        t_status();
        t_refuse();
        t_queue();
        end_of_test();
    end
endmodule

`default_nettype wire

// ===== verilog/aaops_alu.sv
// Eight-bit adder and AND unit with carry, half carry and zero outputs
`timescale 1ns/1ps
`default_nettype none

module aaops_alu (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    // Select add (1) or AND (0)
    input wire logic do_add,
    // Results
    output logic [7:0] result,
    output logic carry,
    output logic half_carry,
    output logic zero
);

    // Full sum with carry out of bit 7
    wire [8:0] sum9 = {1'b0, a} + {1'b0, b};
    // Low nibble sum with carry out of bit 3
    wire [4:0] sum5 = {1'b0, a[3:0]} + {1'b0, b[3:0]};

    assign result = do_add ? sum9[7:0] : (a & b);
    assign carry = sum9[8];
    assign half_carry = sum5[4];
    assign zero = (result == 8'h00);

endmodule
`default_nettype wire

// ===== verilog/aaops_pkg.sv
// Shared constants for the accumulator add/AND execution block
package aaops_pkg;

    // Data and instruction widths
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int AXI_ADDR_W = 4;

    // Register byte offsets on the bus
    localparam logic [3:0] OFS_ACC = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_INSTR = 4'h8;
    localparam logic [3:0] OFS_LAST = 4'hc;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [13:0] INSTR_RST = 14'h0000;

    // Flag positions inside the status byte
    localparam int FLAG_OVF = 0;
    localparam int FLAG_HOVF = 1;
    localparam int FLAG_NULL = 2;

    // Status register address in the file register space
    localparam logic [6:0] STATUS_FADDR_DEF = 7'h03;

    // Opcode fields, bits 13:8 of the instruction word (bits 13:9 for add immediate)
    localparam logic [4:0] OPC_ADD_IMM = 5'h1f;
    localparam logic [5:0] OPC_AND_IMM = 6'h39;
    localparam logic [5:0] OPC_ADD_OPR = 6'h07;
    localparam logic [5:0] OPC_AND_OPR = 6'h05;

    // Field positions in the instruction word
    localparam int TGT_BIT = 7;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded operation, one-hot
    typedef enum logic [4:0] {
        OP_NONE = 5'h01,
        OP_ADD_IMM = 5'h02,
        OP_AND_IMM = 5'h04,
        OP_ADD_OPR = 5'h08,
        OP_AND_OPR = 5'h10
    } aaops_op_t;

endpackage

// ===== verilog/aaops_top.sv
// Execution datapath for add/AND with immediate or file register operand
// How it works
// - Add immediate to accumulator, result in accumulator
// - Add immediate updates all three flags, one cycle
// - AND immediate with accumulator into accumulator
// - AND immediate changes only null flag
// - Add file register to accumulator, three flags
// - Add target bit selects accumulator or file
// - AND file register, only null flag changes unless the target is status
// - AND target bit selects accumulator or file
// - Operation flags override data written to status
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module aaops_top #(
    parameter logic [6:0] STATUS_FADDR = aaops_pkg::STATUS_FADDR_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction from the decoder
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    // File register read port
    output logic [6:0] file_raddr,
    input wire logic [7:0] file_rdata,
    // File register write port
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata,
    // Core state
    output logic [7:0] acc_out,
    output logic [2:0] flags_out,
    output logic exec_done,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Classify an instruction word; bit 8 of add immediate is ignored
    function automatic aaops_pkg::aaops_op_t decode_op(input logic [13:0] w);
        aaops_pkg::aaops_op_t op;
        op = aaops_pkg::OP_NONE;
        if (w[13:9] == aaops_pkg::OPC_ADD_IMM)
            op = aaops_pkg::OP_ADD_IMM;
        else if (w[13:8] == aaops_pkg::OPC_AND_IMM)
            op = aaops_pkg::OP_AND_IMM;
        else if (w[13:8] == aaops_pkg::OPC_ADD_OPR)
            op = aaops_pkg::OP_ADD_OPR;
        else if (w[13:8] == aaops_pkg::OPC_AND_OPR)
            op = aaops_pkg::OP_AND_OPR;
        return op;
    endfunction

    // Architectural state
    logic [7:0] acc_r; // Accumulator
    logic [2:0] flags_r; // Null, half overflow, overflow
    logic [13:0] sw_word_r; // Instruction queued by software
    logic pend_r; // Software instruction waiting
    logic [7:0] last_res_r; // Result of the last executed op
    logic [4:0] last_op_r; // One-hot code of the last op
    logic file_we_r;
    logic [6:0] file_waddr_r;
    logic [7:0] file_wdata_r;
    logic exec_done_r;

    // Bus slave state
    logic aw_hold_r;
    logic [3:0] aw_addr_r;
    logic w_hold_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Instruction source: the decoder always wins, software fills idle cycles
    wire exec_go = instr_valid | pend_r;
    wire [13:0] cur_word = instr_valid ? instr_word : sw_word_r;
    aaops_pkg::aaops_op_t cur_op;
    assign cur_op = decode_op(cur_word);

    // Operation class wires
    wire op_add_imm = (cur_op == aaops_pkg::OP_ADD_IMM);
    wire op_and_imm = (cur_op == aaops_pkg::OP_AND_IMM);
    wire op_add_opr = (cur_op == aaops_pkg::OP_ADD_OPR);
    wire op_and_opr = (cur_op == aaops_pkg::OP_AND_OPR);
    wire op_is_add = op_add_imm | op_add_opr;
    wire op_is_opr = op_add_opr | op_and_opr;
    wire op_known = op_is_add | op_and_imm | op_and_opr;
    wire do_exec = exec_go & op_known;

    // Operand address goes straight out so the array answers this cycle
    wire [6:0] opr_addr = cur_word[6:0];
    assign file_raddr = opr_addr;
    wire opr_is_status = (opr_addr == STATUS_FADDR);

    // Status is held here, so its flag bits are patched into the operand
    wire [7:0] opr_val = opr_is_status ? {file_rdata[7:3], flags_r} : file_rdata;

    wire [7:0] b_operand = op_is_opr ? opr_val : cur_word[7:0];

    // Arithmetic unit
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_dc;
    wire alu_z;
    aaops_alu u_alu (
        .a(acc_r),
        .b(b_operand),
        .do_add(op_is_add),
        .result(alu_res),
        .carry(alu_c),
        .half_carry(alu_dc),
        .zero(alu_z)
    );

    wire to_file = op_is_opr & cur_word[aaops_pkg::TGT_BIT];
    wire to_status = to_file & opr_is_status;

    wire new_c = op_is_add ? alu_c :
        (to_status ? alu_res[aaops_pkg::FLAG_OVF] : flags_r[aaops_pkg::FLAG_OVF]);
    wire new_dc = op_is_add ? alu_dc :
        (to_status ? alu_res[aaops_pkg::FLAG_HOVF] : flags_r[aaops_pkg::FLAG_HOVF]);
    wire [2:0] new_flags = {alu_z, new_dc, new_c};

    wire [7:0] file_data_nxt = to_status ? {alu_res[7:3], new_flags} : alu_res;

    // Bus decode
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
    wire wr_acc = wr_fire & (aw_addr_r == aaops_pkg::OFS_ACC) & w_strb_r[0];
    wire wr_stat = wr_fire & (aw_addr_r == aaops_pkg::OFS_STATUS) & w_strb_r[0];
    wire wr_instr = wr_fire & (aw_addr_r == aaops_pkg::OFS_INSTR);
    wire wr_mapped = (aw_addr_r == aaops_pkg::OFS_ACC) |
        (aw_addr_r == aaops_pkg::OFS_STATUS) | (aw_addr_r == aaops_pkg::OFS_INSTR);
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire ar_mapped = (s_axi_araddr == aaops_pkg::OFS_ACC) |
        (s_axi_araddr == aaops_pkg::OFS_STATUS) |
        (s_axi_araddr == aaops_pkg::OFS_INSTR) |
        (s_axi_araddr == aaops_pkg::OFS_LAST);

    // Byte-lane merge of the queued instruction word
    wire [13:0] sw_word_merge = {
        w_strb_r[1] ? w_data_r[13:8] : sw_word_r[13:8],
        w_strb_r[0] ? w_data_r[7:0] : sw_word_r[7:0]
    };

    // Read data selection; upper bits read as zero
    wire [31:0] rd_mux =
        (s_axi_araddr == aaops_pkg::OFS_ACC) ? {24'h0, acc_r} :
        (s_axi_araddr == aaops_pkg::OFS_STATUS) ? {29'h0, flags_r} :
        (s_axi_araddr == aaops_pkg::OFS_INSTR) ? {17'h0, pend_r, sw_word_r} :
        (s_axi_araddr == aaops_pkg::OFS_LAST) ? {19'h0, last_op_r, last_res_r} :
        32'h00000000;

    // Next accumulator: an op executing into the accumulator wins over a software write
    // sum into accumulator
    wire [7:0] acc_nxt = (do_exec & ~to_file) ? alu_res :
        (wr_acc ? w_data_r[7:0] : acc_r);

    // Next flags: hardware update wins over a software write
    wire [2:0] flags_nxt = do_exec ? new_flags :
        (wr_stat ? w_data_r[2:0] : flags_r);

    // Software queue: a new write wins over the clear of the same cycle
    wire pend_nxt = wr_instr ? 1'b1 : (pend_r & instr_valid);

    // Accumulator and flags, one cycle per instruction
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_r <= aaops_pkg::ACC_RST;
            flags_r <= aaops_pkg::FLAGS_RST;
        end
        else
        begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
        end
    end

    // File write port, registered
    // sum back to file
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            file_we_r <= 1'b0;
            file_waddr_r <= 7'h00;
            file_wdata_r <= 8'h00;
        end
        else
        begin
            file_we_r <= do_exec & to_file;
            file_waddr_r <= opr_addr;
            file_wdata_r <= file_data_nxt;
        end
    end

    // Trace of the last executed operation
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_res_r <= 8'h00;
            last_op_r <= 5'h00;
            exec_done_r <= 1'b0;
        end
        else
        begin
            exec_done_r <= do_exec;
            // Unknown opcodes leave the trace alone
            if (do_exec)
            begin
                last_res_r <= alu_res;
                last_op_r <= cur_op;
            end
        end
    end

    // Software instruction queue, one deep
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_word_r <= aaops_pkg::INSTR_RST;
            pend_r <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
            if (wr_instr)
                sw_word_r <= sw_word_merge;
        end
    end

    // Write address and data holding, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_hold_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            else if (wr_fire)
                aw_hold_r <= 1'b0;
            if (w_take)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_hold_r <= 1'b0;
        end
    end

    // Write response; unmapped or read-only offsets answer slave error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= aaops_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? aaops_pkg::RESP_OKAY : aaops_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // Read channel, one request at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= aaops_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= ar_mapped ? aaops_pkg::RESP_OKAY : aaops_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Ready terms: a held beat blocks a second one until the response
    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready = ~w_hold_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;

    // Output drive
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign file_we = file_we_r;
    assign file_waddr = file_waddr_r;
    assign file_wdata = file_wdata_r;
    assign acc_out = acc_r;
    assign flags_out = flags_r;
    assign exec_done = exec_done_r;

    // Protection bits carry no meaning here
    wire unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_r[31:14]};

endmodule
`default_nettype wire
